/* File: guard_map.svh */
// Offsets, codes and timing counts of the system guard timer.
`ifndef GUARD_MAP_SVH
`define GUARD_MAP_SVH
`define IDX_PORT_ADDR 8'h2E
`define DATA_PORT_ADDR 8'h2F
`define UNLOCK_KEY 8'h87
`define LOCK_KEY 8'hAA
`define OFF_UNIT_SELECT 8'h07
`define OFF_UNIT_ENABLE 8'h30
`define OFF_ARM_CONTROL 8'hF0
`define OFF_TIME_BASE 8'hF5
`define OFF_COUNTDOWN 8'hF6
`define GUARD_UNIT_NUM 8'h07
`define UNIT_ENABLE_BIT 0
`define ARM_BIT 7
`define TB_SECONDS 8'h71
`define TB_MINUTES 8'h79
`define RST_UNIT_SELECT 8'h00
`define RST_UNIT_ENABLE 8'h00
`define RST_ARM_CONTROL 8'h00
`define RST_TIME_BASE 8'h71
`define RST_COUNTDOWN 8'h00
`define CLK_HZ 10000000
`define SECOND_NS 1000000000
`define CLK_PERIOD_NS 100
`define SECOND_CYCLES (`SECOND_NS / `CLK_PERIOD_NS)
`define SECONDS_PER_MINUTE 60
`define REBOOT_PULSE_CYCLES 16
`endif

/* File: guard_pkg.sv */
// Types shared by the system guard timer modules.
package guard_pkg;
  typedef enum logic [1:0] {CFG_LOCKED, CFG_HALF, CFG_OPEN} cfg_state_t;
  typedef enum logic {BASE_SECOND, BASE_MINUTE} base_t;
endpackage

/* File: tick_if.sv */
// Time-base tick carrier between the guard top and its prescaler.
`timescale 1ns/1ps
interface tick_if;
  logic run;
  logic minute_mode;
  logic restart;
  logic tick;
  modport ctrl (output run, output minute_mode, output restart, input tick);
  modport gen (input run, input minute_mode, input restart, output tick);
endinterface

/* File: guard_prescaler.sv */
// Prescaler producing one pulse per countdown unit.
`timescale 1ns/1ps
`include "guard_map.svh"
module guard_prescaler
  import guard_pkg::*;
#(
  parameter int unsigned SECOND_CYC = `SECOND_CYCLES
)
(
  input wire logic clk,
  input wire logic reset,
  tick_if.gen tb
);
  logic [31:0] sec_cnt_r;
  logic [31:0] sec_cnt_nxt;
  logic [5:0] min_cnt_r;
  logic [5:0] min_cnt_nxt;
  logic tick_r;
  logic tick_nxt;
  logic sec_pulse;

  //////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    sec_cnt_nxt = sec_cnt_r;
    min_cnt_nxt = min_cnt_r;
    tick_nxt = 1'b0;
    sec_pulse = 1'b0;
    if (!tb.run || tb.restart)
    begin
      sec_cnt_nxt = 32'h0;
      min_cnt_nxt = 6'h0;
    end
    else if (sec_cnt_r == SECOND_CYC - 1)
    begin
      sec_cnt_nxt = 32'h0;
      sec_pulse = 1'b1;
    end
    else
    begin
      sec_cnt_nxt = sec_cnt_r + 32'h1;
    end
    // A minute unit is built from sixty seconds so both bases share one divider.
    if (sec_pulse)
    begin
      if (!tb.minute_mode)
      begin
        tick_nxt = 1'b1;
        min_cnt_nxt = 6'h0;
      end
      else if (min_cnt_r == 6'(`SECONDS_PER_MINUTE - 1))
      begin
        tick_nxt = 1'b1;
        min_cnt_nxt = 6'h0;
      end
      else
      begin
        min_cnt_nxt = min_cnt_r + 6'h1;
      end
    end
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      sec_cnt_r <= 32'h0;
      min_cnt_r <= 6'h0;
      tick_r <= 1'b0;
    end
    else
    begin
      sec_cnt_r <= sec_cnt_nxt;
      min_cnt_r <= min_cnt_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign tb.tick = tick_r;

  AST_TICK_ONE_CYCLE: assert property (@(posedge clk) disable iff (reset)
    tb.tick |=> !tb.tick)
    else $error("Unit tick lasted more than one cycle.");
endmodule

/* File: system_guard_timer.sv */
// Top of the system guard timer with its index/data configuration port.
// Behaviour
// - Countdown value selects one of 1 to 255 timeout levels.
// - Loading a value with the timer enabled starts the countdown automatically.
// - Reaching zero without reload or disable triggers a reboot.
// - Two 87h writes to port 2Eh unlock; then index at 2Eh, data 2Fh.
// - Select unit 07h, enable with 01h at 30h, arm with 80h at F0h.
// - Time value at F6h; 00h disables timeout, nonzero sets count.
// - Seconds base with FFh loaded times out after 255 seconds.
// - Writing 71h at F5h makes each unit one second.
// - Writing 79h at F5h makes each unit one minute.
`timescale 1ns/1ps
`include "guard_map.svh"
module system_guard_timer
  import guard_pkg::*;
#(
  parameter int unsigned SECOND_CYC = `SECOND_CYCLES
)
(
  input wire logic clk,
  input wire logic reset,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_addr,
  input wire logic [7:0] io_wdata,
  output logic [7:0] io_rdata,
  output logic reboot,
  output logic timer_running
);
  cfg_state_t cfg_r;
  cfg_state_t cfg_nxt;
  logic [7:0] index_r;
  logic [7:0] index_nxt;
  logic [7:0] unit_sel_r;
  logic [7:0] unit_sel_nxt;
  logic [7:0] unit_en_r;
  logic [7:0] unit_en_nxt;
  logic [7:0] arm_r;
  logic [7:0] arm_nxt;
  logic [7:0] base_r;
  logic [7:0] base_nxt;
  logic [7:0] value_r;
  logic [7:0] value_nxt;
  logic [7:0] count_r;
  logic [7:0] count_nxt;
  logic [4:0] pulse_r;
  logic [4:0] pulse_nxt;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic idx_wr;
  logic dat_wr;
  logic dat_rd;
  logic unit_hit;
  logic load;
  logic active;
  logic expire;

  tick_if tb ();

  guard_prescaler #(.SECOND_CYC(SECOND_CYC)) u_prescaler (
    .clk(clk),
    .reset(reset),
    .tb(tb.gen)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Port decode. The data port is dead while locked so stray I/O cannot arm it.
  assign idx_wr = io_wr && (io_addr == `IDX_PORT_ADDR);
  assign dat_wr = io_wr && (io_addr == `DATA_PORT_ADDR) && (cfg_r == CFG_OPEN);
  assign dat_rd = io_rd && (io_addr == `DATA_PORT_ADDR) && (cfg_r == CFG_OPEN);
  assign unit_hit = (unit_sel_r == `GUARD_UNIT_NUM);
  assign load = dat_wr && unit_hit && (index_r == `OFF_COUNTDOWN);
  assign active = unit_en_r[`UNIT_ENABLE_BIT] && arm_r[`ARM_BIT];

  always_comb
  begin
    cfg_nxt = cfg_r;
    index_nxt = index_r;
    unique case (cfg_r)
      CFG_LOCKED:
      begin
        if (idx_wr && io_wdata == `UNLOCK_KEY)
        begin
          cfg_nxt = CFG_HALF;
        end
      end
      CFG_HALF:
      begin
        if (idx_wr)
        begin
          cfg_nxt = (io_wdata == `UNLOCK_KEY) ? CFG_OPEN : CFG_LOCKED;
        end
      end
      CFG_OPEN:
      begin
        if (idx_wr && io_wdata == `LOCK_KEY)
        begin
          cfg_nxt = CFG_LOCKED;
        end
        else if (idx_wr)
        begin
          index_nxt = io_wdata;
        end
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    unit_sel_nxt = unit_sel_r;
    unit_en_nxt = unit_en_r;
    arm_nxt = arm_r;
    base_nxt = base_r;
    value_nxt = value_r;
    if (dat_wr && index_r == `OFF_UNIT_SELECT)
    begin
      unit_sel_nxt = io_wdata;
    end
    if (dat_wr && unit_hit)
    begin
      unique case (index_r)
        `OFF_UNIT_ENABLE: unit_en_nxt = io_wdata;
        `OFF_ARM_CONTROL: arm_nxt = io_wdata;
        `OFF_TIME_BASE: base_nxt = io_wdata;
        `OFF_COUNTDOWN: value_nxt = io_wdata;
        default: ;
      endcase
    end
  end

  always_comb
  begin
    rdata_nxt = rdata_r;
    if (io_rd && io_addr == `IDX_PORT_ADDR)
    begin
      rdata_nxt = index_r;
    end
    else if (dat_rd)
    begin
      rdata_nxt = 8'h00;
      if (index_r == `OFF_UNIT_SELECT)
      begin
        rdata_nxt = unit_sel_r;
      end
      else if (unit_hit)
      begin
        unique case (index_r)
          `OFF_UNIT_ENABLE: rdata_nxt = unit_en_r;
          `OFF_ARM_CONTROL: rdata_nxt = arm_r;
          `OFF_TIME_BASE: rdata_nxt = base_r;
          // Reading the time value shows the live remaining count while running.
          `OFF_COUNTDOWN: rdata_nxt = timer_running ? count_r : value_r;
          default: rdata_nxt = 8'h00;
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Countdown. Only the 79h code selects minutes; every other code keeps seconds.
  assign tb.run = active && (count_r != 8'h00);
  assign tb.minute_mode = (base_r == `TB_MINUTES);
  assign tb.restart = load;
  assign expire = tb.run && tb.tick && (count_r == 8'h01);

  always_comb
  begin
    count_nxt = count_r;
    pulse_nxt = pulse_r;
    if (load)
    begin
      count_nxt = io_wdata;
    end
    else if (!active)
    begin
      count_nxt = 8'h00;
    end
    else if (tb.run && tb.tick)
    begin
      count_nxt = count_r - 8'h01;
    end
    if (expire)
    begin
      pulse_nxt = 5'(`REBOOT_PULSE_CYCLES);
    end
    else if (pulse_r != 5'h00)
    begin
      pulse_nxt = pulse_r - 5'h01;
    end
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      cfg_r <= CFG_LOCKED;
      index_r <= 8'h00;
      unit_sel_r <= `RST_UNIT_SELECT;
      unit_en_r <= `RST_UNIT_ENABLE;
      arm_r <= `RST_ARM_CONTROL;
      base_r <= `RST_TIME_BASE;
      value_r <= `RST_COUNTDOWN;
      count_r <= 8'h00;
      pulse_r <= 5'h00;
      rdata_r <= 8'h00;
    end
    else
    begin
      cfg_r <= cfg_nxt;
      index_r <= index_nxt;
      unit_sel_r <= unit_sel_nxt;
      unit_en_r <= unit_en_nxt;
      arm_r <= arm_nxt;
      base_r <= base_nxt;
      value_r <= value_nxt;
      count_r <= count_nxt;
      pulse_r <= pulse_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign io_rdata = rdata_r;
  assign reboot = (pulse_r != 5'h00);
  assign timer_running = tb.run;

  //////////////////////////////////////////////////////////////////////////////
  AST_LOAD_SETS_COUNT: assert property (@(posedge clk) disable iff (reset)
    load |=> count_r == $past(io_wdata))
    else $error("Time value write did not restart the count.");
  AST_ZERO_NO_RUN: assert property (@(posedge clk) disable iff (reset)
    load && io_wdata == 8'h00 |=> !timer_running [*4])
    else $error("Zero time value left the timer running.");
  AST_AUTO_START: assert property (@(posedge clk) disable iff (reset)
    load && active && io_wdata != 8'h00 && !arm_nxt[`ARM_BIT] == 1'b0 |=> timer_running)
    else $error("Countdown did not start after load.");
  // The pulse length is held by its counter, so a long repetition is never unrolled.
  AST_REBOOT_ON_EXPIRE: assert property (@(posedge clk) disable iff (reset)
    expire |=> reboot && pulse_r == 5'(`REBOOT_PULSE_CYCLES))
    else $error("Reboot pulse did not start at full length after expiry.");
  AST_PULSE_COUNTS_DOWN: assert property (@(posedge clk) disable iff (reset)
    pulse_r != 5'h00 && !expire |=> pulse_r == $past(pulse_r) - 5'h01)
    else $error("Reboot pulse counter did not step down.");
  AST_NO_REBOOT_IDLE: assert property (@(posedge clk) disable iff (reset)
    $rose(reboot) |-> $past(expire))
    else $error("Reboot without countdown expiry.");
  AST_DECREMENT_BY_ONE: assert property (@(posedge clk) disable iff (reset)
    tb.run && tb.tick && !load && active |=> count_r == $past(count_r) - 8'h01)
    else $error("Count did not step down by one unit.");
  AST_LOCKED_IGNORES: assert property (@(posedge clk) disable iff (reset)
    cfg_r != CFG_OPEN && io_wr |=> $stable(value_r) && $stable(arm_r))
    else $error("Locked port changed a register.");
  AST_DISABLE_STOPS: assert property (@(posedge clk) disable iff (reset)
    !active && !load |=> count_r == 8'h00)
    else $error("Disabled timer kept counting.");
  AST_MINUTE_MODE: assert property (@(posedge clk) disable iff (reset)
    tb.minute_mode && tb.tick |-> $past(u_prescaler.min_cnt_r) == 6'(`SECONDS_PER_MINUTE - 1))
    else $error("Minute unit ended before sixty seconds.");

  COV_UNLOCK: cover property (@(posedge clk) disable iff (reset)
    cfg_r == CFG_HALF ##1 cfg_r == CFG_OPEN);
  COV_LOAD_RUN: cover property (@(posedge clk) disable iff (reset)
    load ##1 timer_running);
  COV_EXPIRE: cover property (@(posedge clk) disable iff (reset) expire);
  COV_RELOAD: cover property (@(posedge clk) disable iff (reset)
    timer_running && load);
endmodule

/* File: host_model.sv */
// Host software model issuing index and data port cycles.
`timescale 1ns/1ps
`include "guard_map.svh"
module host_model
(
  input wire logic clk,
  input wire logic [7:0] io_rdata,
  output logic io_wr,
  output logic io_rd,
  output logic [7:0] io_addr,
  output logic [7:0] io_wdata
);
  initial
  begin
    io_wr = 1'b0;
    io_rd = 1'b0;
    io_addr = 8'h00;
    io_wdata = 8'h00;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Idle lines show the inverse of the last value so stale data never looks valid.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    io_wr <= 1'b1;
    io_addr <= a;
    io_wdata <= d;
    @(posedge clk);
    io_wr <= 1'b0;
    io_addr <= ~a;
    io_wdata <= ~d;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk);
    io_rd <= 1'b1;
    io_addr <= a;
    @(posedge clk);
    io_rd <= 1'b0;
    io_addr <= ~a;
    #1;
    v = io_rdata;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic unlock();
    wr(`IDX_PORT_ADDR, `UNLOCK_KEY);
    wr(`IDX_PORT_ADDR, `UNLOCK_KEY);
  endtask
  task automatic put(input logic [7:0] i, input logic [7:0] d);
    wr(`IDX_PORT_ADDR, i);
    wr(`DATA_PORT_ADDR, d);
  endtask
  task automatic get(input logic [7:0] i, output logic [7:0] v);
    wr(`IDX_PORT_ADDR, i);
    rd(`DATA_PORT_ADDR, v);
  endtask
  task automatic setup(input logic [7:0] unit);
    put(`OFF_UNIT_SELECT, unit);
    put(`OFF_UNIT_ENABLE, 8'h01);
    put(`OFF_ARM_CONTROL, 8'h80);
  endtask
endmodule

/* File: testbench.sv */
// Self-checking bench of the system guard timer.
`timescale 1ns/1ps
`include "guard_map.svh"
module testbench;
  import guard_pkg::*;
  localparam int SC = 4;
  logic clk;
  logic reset;
  logic io_wr;
  logic io_rd;
  logic [7:0] io_addr;
  logic [7:0] io_wdata;
  logic [7:0] io_rdata;
  logic [7:0] v;
  logic reboot;
  logic timer_running;
  integer fail_count = 0;
  integer checks_done = 0;
  integer seed = 32'h3871;
  integer n;
  system_guard_timer #(.SECOND_CYC(SC)) dut (.clk(clk), .reset(reset), .io_wr(io_wr),
    .io_rd(io_rd), .io_addr(io_addr), .io_wdata(io_wdata), .io_rdata(io_rdata),
    .reboot(reboot), .timer_running(timer_running));
  host_model host (.clk(clk), .io_rdata(io_rdata), .io_wr(io_wr), .io_rd(io_rd),
    .io_addr(io_addr), .io_wdata(io_wdata));
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      fail_count++;
    end
  endtask
  // Cycles are counted as edges after the edge that takes the load write.
  task automatic expire(input integer exp_cyc);
    integer c;
    integer t;
    c = 0;
    while (reboot !== 1'b1 && c < 20000)
    begin
      @(posedge clk);
      #1;
      c++;
    end
    if (c >= 20000)
    begin
      fail_count++;
      summarize();
    end
    chk(c, exp_cyc);
    t = 0;
    while (reboot === 1'b1 && t < 40)
    begin
      @(posedge clk);
      #1;
      t++;
    end
    chk(t, `REBOOT_PULSE_CYCLES);
    chk(timer_running, 1'b0);
  endtask
  task automatic quiet(input integer cyc);
    integer t;
    t = 0;
    repeat (cyc)
    begin
      @(posedge clk);
      #1;
      if (reboot !== 1'b0)
        t++;
    end
    chk(t, 0);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    reset = 1'b1;
    repeat (20) @(posedge clk);
    chk(io_rdata, 8'h00);
    chk(reboot, 1'b0);
    reset <= 1'b0;
    host.put(`OFF_COUNTDOWN, 8'($random(seed) | 1));
    host.rd(`DATA_PORT_ADDR, v);
    chk(v, 8'h00);
    chk(timer_running, 1'b0);
    $display("test locked done");
    host.unlock();
    host.setup(8'h06);
    host.put(`OFF_COUNTDOWN, 8'h05);
    chk(timer_running, 1'b0);
    host.setup(`GUARD_UNIT_NUM);
    host.get(`OFF_TIME_BASE, v);
    chk(v, `RST_TIME_BASE);
    host.get(`OFF_ARM_CONTROL, v);
    chk(v, 8'h80);
    $display("test setup done");
    n = 1 + ($unsigned($random(seed)) % 255);
    host.put(`OFF_TIME_BASE, `TB_SECONDS);
    host.put(`OFF_COUNTDOWN, 8'(n));
    chk(timer_running, 1'b1);
    expire(n * SC + 1);
    host.put(`OFF_COUNTDOWN, 8'h0A);
    repeat (20) @(posedge clk);
    host.put(`OFF_COUNTDOWN, 8'h05);
    expire(5 * SC + 1);
    $display("test seconds and reload done");
    host.put(`OFF_COUNTDOWN, 8'h0A);
    host.put(`OFF_COUNTDOWN, 8'h00);
    chk(timer_running, 1'b0);
    quiet(60);
    host.put(`OFF_TIME_BASE, `TB_MINUTES);
    host.put(`OFF_COUNTDOWN, 8'h02);
    expire(2 * `SECONDS_PER_MINUTE * SC + 1);
    host.put(`OFF_TIME_BASE, `TB_SECONDS);
    host.put(`OFF_COUNTDOWN, 8'hFF);
    expire(255 * SC + 1);
    $display("test bases and limits done");
    host.put(`OFF_COUNTDOWN, 8'h09);
    host.put(`OFF_UNIT_ENABLE, 8'h00);
    chk(timer_running, 1'b0);
    quiet(60);
    host.wr(`IDX_PORT_ADDR, `LOCK_KEY);
    host.put(`OFF_ARM_CONTROL, 8'h00);
    host.unlock();
    host.get(`OFF_ARM_CONTROL, v);
    chk(v, 8'h80);
    $display("test disable done");
    summarize();
  end
endmodule
